// File: hw/xcvr_mgmt_consts.svh
// offsets, field positions, reset values and timing figures of the management block
`ifndef XCVR_MGMT_CONSTS_SVH
`define XCVR_MGMT_CONSTS_SVH

// lower page
`define LO_TYPE_CODE      8'h00
`define LO_STATUS         8'h02
`define LO_FLAGS          8'h03
`define LO_MASK           8'h64
`define LO_PAGE_SEL       8'h7f
`define STATUS_NOT_READY  0
// upper page 00 identification map
`define ID_TYPE_CODE      8'h80
`define ID_EXT_TYPE       8'h81
`define ID_CONNECTOR      8'h82
`define ID_COMPAT         8'h83
`define ID_ENCODING       8'h8b
`define ID_BIT_RATE       8'h8c
`define ID_RATE_TAGS      8'h8d
`define ID_SMF_KM         8'h8e
`define ID_EMM50_2M       8'h8f
`define ID_MM50_M         8'h90
`define ID_MM62_M         8'h91
`define ID_COPPER_M       8'h92
`define ID_DEV_TECH       8'h93
`define ID_MAKER_NAME     8'h94
`define ID_EXT_COMPAT     8'ha4
`define ID_ORG_ID         8'ha5
`define ID_PART_NUM       8'ha8
`define ID_PART_REV       8'hb8
`define ID_WAVELEN        8'hba
`define ID_WAVE_TOL       8'hbc
`define ID_MAX_TEMP       8'hbe
`define ID_BASE_SUM       8'hbf
`define ID_OPTIONS        8'hc0
`define ID_SERIAL         8'hc4
`define ID_DATE           8'hd4
`define ID_MON_KIND       8'hdc
`define ID_ENH_FEAT       8'hdd
`define ID_SPARE          8'hde
`define ID_EXT_SUM        8'hdf
`define PAGE_ID           8'h00
`define PAGE_USER         8'h02
`define PAGE_RESET        8'h00
`define MASK_RESET        8'h00
// timing
`define CLK_NS            40
`define CLK_KHZ           25000
`define INIT_TIME_MS      2000
`define RESET_MIN_NS      2000
`define RESET_MIN_CYCLES  ((`RESET_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define INIT_CYCLES       (`INIT_TIME_MS * `CLK_KHZ)

`endif

// File: hw/xcvr_mgmt_pkg.sv
// types shared by the transceiver management block
package xcvr_mgmt_pkg;

	typedef struct packed {
		logic init_done;
		logic tx_fault;
		logic rx_los;
	} flags_t;

	typedef enum logic [6:0] {
		SB_IDLE = 7'b0000001,
		SB_ADDR = 7'b0000010,
		SB_AACK = 7'b0000100,
		SB_WRX  = 7'b0001000,
		SB_WACK = 7'b0010000,
		SB_RTX  = 7'b0100000,
		SB_RACK = 7'b1000000
	} sbus_state_t;

	typedef enum logic [3:0] {
		INIT_HOLD   = 4'b0001,
		INIT_SUM    = 4'b0010,
		INIT_SETTLE = 4'b0100,
		INIT_RUN    = 4'b1000
	} init_state_t;

endpackage : xcvr_mgmt_pkg

// File: hw/xcvr_mgmt.sv
// management logic of the transceiver: id map, user page, flags, interrupt, two-wire slave
// Function
// - nominal bit rate byte at 140, 100 Mb/s units
// - wavelength at 186-187, value over 20 nm
// - wavelength tolerance at 188-189, value over 200
// - base check code at 191 covers 128-190
// - extended check code at 223 covers 192-222
// - reach bytes in km, 2 m, 1 m units
// - text fields ascii, serial sixteen bytes 196-211
// - upper page two is host-defined user storage
// - fully functional within 2000 ms of reset
// - reset pin low counts only beyond 2 us
// - serial bus answers within 2000 ms
// - not-ready bit clears and interrupt asserts
// - functional within 2000 ms after reset pin rises
// - low power entered within 100 us of request
// - interrupt asserted within 200 ms of condition
// - flags clear on read, interrupt releases quickly
// - loss-of-signal sets flag and interrupt within 100 ms
// - other flags set with interrupt within 200 ms
// - setting mask inhibits interrupt within 100 ms
// - clearing mask resumes interrupt within 100 ms
// - functional once not-ready clears and interrupt asserts
// - page select byte 127 picks upper page
// - read clears take effect at stop condition
`include "xcvr_mgmt_consts.svh"

module xcvr_mgmt #(
	parameter logic [6:0]   DEV_ADDR     = 7'h50,
	parameter int           INIT_CYCLES  = `INIT_CYCLES,
	parameter int           SETTLE_CYCLES = `INIT_CYCLES / 4,
	parameter logic [7:0]   TYPE_CODE    = 8'h01, // arbitrary value
	parameter logic [7:0]   BIT_RATE     = 8'h00,
	parameter logic [7:0]   SMF_KM       = 8'h00,
	parameter logic [7:0]   EMM50_2M     = 8'h00,
	parameter logic [7:0]   MM50_M       = 8'h00,
	parameter logic [7:0]   MM62_M       = 8'h00,
	parameter logic [7:0]   COPPER_M     = 8'h00,
	parameter logic [15:0]  WAVELEN      = 16'h0000,
	parameter logic [15:0]  WAVE_TOL     = 16'h0000,
	parameter logic [7:0]   MAX_TEMP     = 8'h00,
	parameter logic [23:0]  ORG_ID       = 24'h000001, // arbitrary value
	parameter logic [127:0] MAKER_NAME   = {16{8'h20}},
	parameter logic [127:0] PART_NUM     = {16{8'h20}},
	parameter logic [15:0]  PART_REV     = {2{8'h20}},
	parameter logic [127:0] SERIAL_NUM   = {16{8'h20}},
	parameter logic [63:0]  DATE_CODE    = {8{8'h20}}
) (
	input  wire logic mclk_in,
	input  wire logic reset_n_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n_out,
	input  wire logic module_reset_n_in,
	input  wire logic low_power_request_in,
	input  wire logic rx_los_in,
	input  wire logic tx_fault_in,
	output logic      interrupt_request_n_out,
	output logic      low_power_active_out,
	output logic      ready_out
);

	function automatic logic [7:0] text_byte(input logic [127:0] txt, input logic [3:0] idx);
		text_byte = txt[8 * (15 - idx) +: 8];
	endfunction : text_byte

	// check code bytes read as zero here, the computed sums are muxed in by rd_byte
	function automatic logic [7:0] id_rom(input logic [7:0] a);
		id_rom = 8'h00;
		if (a >= `ID_MAKER_NAME && a < `ID_EXT_COMPAT)
			id_rom = text_byte(MAKER_NAME, 4'(a - `ID_MAKER_NAME));
		else if (a >= `ID_PART_NUM && a < `ID_PART_REV)
			id_rom = text_byte(PART_NUM, 4'(a - `ID_PART_NUM));
		else if (a >= `ID_SERIAL && a < `ID_DATE)
			id_rom = text_byte(SERIAL_NUM, 4'(a - `ID_SERIAL));
		else if (a >= `ID_DATE && a < `ID_MON_KIND)
			id_rom = DATE_CODE[8 * (7 - 32'(a - `ID_DATE)) +: 8];
		else
			case (a)
				`ID_TYPE_CODE:     id_rom = TYPE_CODE;
				`ID_BIT_RATE:      id_rom = BIT_RATE;
				`ID_SMF_KM:        id_rom = SMF_KM;
				`ID_EMM50_2M:      id_rom = EMM50_2M;
				`ID_MM50_M:        id_rom = MM50_M;
				`ID_MM62_M:        id_rom = MM62_M;
				`ID_COPPER_M:      id_rom = COPPER_M;
				`ID_ORG_ID:        id_rom = ORG_ID[23:16];
				`ID_ORG_ID + 8'h1: id_rom = ORG_ID[15:8];
				`ID_ORG_ID + 8'h2: id_rom = ORG_ID[7:0];
				`ID_PART_REV:      id_rom = PART_REV[15:8];
				`ID_PART_REV + 8'h1: id_rom = PART_REV[7:0];
				`ID_WAVELEN:       id_rom = WAVELEN[15:8];
				`ID_WAVELEN + 8'h1: id_rom = WAVELEN[7:0];
				`ID_WAVE_TOL:      id_rom = WAVE_TOL[15:8];
				`ID_WAVE_TOL + 8'h1: id_rom = WAVE_TOL[7:0];
				`ID_MAX_TEMP:      id_rom = MAX_TEMP;
				default:           id_rom = 8'h00;
			endcase
	endfunction : id_rom

	// synchronisers: first stage feeds only the second
	logic scl_s1_ff, scl_s2_ff, scl_d_ff, sda_s1_ff, sda_s2_ff, sda_d_ff;
	logic mrst_s1_ff, mrst_s2_ff, lp_s1_ff, lp_s2_ff;
	logic los_s1_ff, los_s2_ff, flt_s1_ff, flt_s2_ff;

	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			{scl_s1_ff, scl_s2_ff, scl_d_ff} <= 3'h7;
			{sda_s1_ff, sda_s2_ff, sda_d_ff} <= 3'h7;
			{mrst_s1_ff, mrst_s2_ff, lp_s1_ff, lp_s2_ff} <= 4'hc;
			{los_s1_ff, los_s2_ff, flt_s1_ff, flt_s2_ff} <= 4'h0;
		end
		else
		begin
			{scl_d_ff, scl_s2_ff, scl_s1_ff} <= {scl_s2_ff, scl_s1_ff, scl_in};
			{sda_d_ff, sda_s2_ff, sda_s1_ff} <= {sda_s2_ff, sda_s1_ff, sda_in};
			{mrst_s2_ff, mrst_s1_ff} <= {mrst_s1_ff, module_reset_n_in};
			{lp_s2_ff, lp_s1_ff} <= {lp_s1_ff, low_power_request_in};
			{los_s2_ff, los_s1_ff} <= {los_s1_ff, rx_los_in};
			{flt_s2_ff, flt_s1_ff} <= {flt_s1_ff, tx_fault_in};
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise  = scl_s2_ff & ~scl_d_ff;
	assign scl_fall  = ~scl_s2_ff & scl_d_ff;
	assign bus_start = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
	assign bus_stop  = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;

	// module reset pin filter: glitches up to the minimum width are ignored
	localparam int RST_MIN = `RESET_MIN_CYCLES;
	logic [6:0] mrst_lo_cnt_ff;
	logic       hold_ff;

	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			mrst_lo_cnt_ff <= 7'h00;
			hold_ff        <= 1'b0;
		end
		else if (mrst_s2_ff)
		begin
			mrst_lo_cnt_ff <= 7'h00;
			hold_ff        <= 1'b0;
		end
		else if (mrst_lo_cnt_ff <= 7'(RST_MIN))
			mrst_lo_cnt_ff <= mrst_lo_cnt_ff + 7'h01;
		else
			hold_ff <= 1'b1;
	end

	// init sequence: sum the id map, settle, then declare ready
	xcvr_mgmt_pkg::init_state_t init_state_ff;
	logic [7:0]  walk_ff, base_sum_ff, ext_sum_ff;
	logic [31:0] settle_cnt_ff;
	logic        ready_ff;

	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			init_state_ff <= xcvr_mgmt_pkg::INIT_SUM;
			walk_ff       <= `ID_TYPE_CODE;
			base_sum_ff   <= 8'h00;
			ext_sum_ff    <= 8'h00;
			settle_cnt_ff <= 32'h0;
			ready_ff      <= 1'b0;
		end
		else if (hold_ff)
		begin
			init_state_ff <= xcvr_mgmt_pkg::INIT_HOLD;
			ready_ff      <= 1'b0;
		end
		else
			case (init_state_ff)
				xcvr_mgmt_pkg::INIT_HOLD:
				begin
					init_state_ff <= xcvr_mgmt_pkg::INIT_SUM;
					walk_ff       <= `ID_TYPE_CODE;
					base_sum_ff   <= 8'h00;
					ext_sum_ff    <= 8'h00;
				end
				xcvr_mgmt_pkg::INIT_SUM:
				begin
					if (walk_ff < `ID_BASE_SUM)
						base_sum_ff <= base_sum_ff + id_rom(walk_ff);
					else if (walk_ff > `ID_BASE_SUM)
						ext_sum_ff <= ext_sum_ff + id_rom(walk_ff);
					walk_ff <= walk_ff + 8'h01;
					if (walk_ff == `ID_SPARE)
					begin
						init_state_ff <= xcvr_mgmt_pkg::INIT_SETTLE;
						settle_cnt_ff <= 32'h0;
					end
				end
				xcvr_mgmt_pkg::INIT_SETTLE:
				begin
					settle_cnt_ff <= settle_cnt_ff + 32'h1;
					if (settle_cnt_ff >= 32'(SETTLE_CYCLES))
					begin
						init_state_ff <= xcvr_mgmt_pkg::INIT_RUN;
						ready_ff      <= 1'b1;
					end
				end
				xcvr_mgmt_pkg::INIT_RUN:
					ready_ff <= 1'b1;
				default:
					init_state_ff <= xcvr_mgmt_pkg::INIT_HOLD;
			endcase
	end

	// register state: mask, page select and user page written by the host, plus the flags
	logic [7:0] mask_ff, page_ff;
	logic [7:0] user_mem_ff [128];
	xcvr_mgmt_pkg::flags_t flags_ff, clr_bits_ff;

	function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] pg,
		input logic [7:0] fl, input logic [7:0] mk, input logic rdy,
		input logic [7:0] bsum, input logic [7:0] esum, input logic [7:0] ubyte);
		rd_byte = 8'h00;
		if (!a[7])
			case (a)
				`LO_TYPE_CODE: rd_byte = TYPE_CODE;
				`LO_STATUS:    rd_byte = {7'h00, ~rdy};
				`LO_FLAGS:     rd_byte = fl;
				`LO_MASK:      rd_byte = mk;
				`LO_PAGE_SEL:  rd_byte = pg;
				default:       rd_byte = 8'h00;
			endcase
		else if (pg == `PAGE_USER)
			rd_byte = ubyte;
		else if (pg == `PAGE_ID)
			rd_byte = (a == `ID_BASE_SUM) ? bsum : (a == `ID_EXT_SUM) ? esum : id_rom(a);
	endfunction : rd_byte

	// two-wire slave
	xcvr_mgmt_pkg::sbus_state_t sb_state_ff;
	logic [3:0] bit_cnt_ff;
	logic [7:0] shift_ff, ofs_ff, ofs_nx;
	logic       rw_ff, ofs_valid_ff, nack_ff, clr_pend_ff, sda_oe_n_ff;
	logic       wr_stb, clr_stb, byte_end;
	logic [7:0] rd_now, rd_next;

	assign byte_end = scl_fall && bit_cnt_ff == 4'h8;
	assign ofs_nx   = ofs_ff + 8'h01;
	assign wr_stb   = sb_state_ff == xcvr_mgmt_pkg::SB_WRX && byte_end && ofs_valid_ff;
	assign clr_stb  = bus_stop && clr_pend_ff;
	assign rd_now   = rd_byte(ofs_ff, page_ff, {5'h00, flags_ff}, mask_ff, ready_ff,
		base_sum_ff, ext_sum_ff, user_mem_ff[ofs_ff[6:0]]);
	assign rd_next  = rd_byte(ofs_nx, page_ff, {5'h00, flags_ff}, mask_ff, ready_ff,
		base_sum_ff, ext_sum_ff, user_mem_ff[ofs_nx[6:0]]);

	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			sb_state_ff  <= xcvr_mgmt_pkg::SB_IDLE;
			bit_cnt_ff   <= 4'h0;
			shift_ff     <= 8'h00;
			ofs_ff       <= 8'h00;
			rw_ff        <= 1'b0;
			ofs_valid_ff <= 1'b0;
			nack_ff      <= 1'b0;
			clr_pend_ff  <= 1'b0;
			clr_bits_ff  <= '0;
			sda_oe_n_ff  <= 1'b1;
		end
		else if (bus_stop || !ready_ff)
		begin
			sb_state_ff <= xcvr_mgmt_pkg::SB_IDLE;
			sda_oe_n_ff <= 1'b1;
			clr_pend_ff <= 1'b0;
		end
		else if (bus_start)
		begin
			sb_state_ff <= xcvr_mgmt_pkg::SB_ADDR;
			bit_cnt_ff  <= 4'h0;
			sda_oe_n_ff <= 1'b1;
		end
		else
		begin
			if (scl_rise && bit_cnt_ff != 4'h8)
			begin
				shift_ff   <= (sb_state_ff == xcvr_mgmt_pkg::SB_RTX) ? shift_ff
					: {shift_ff[6:0], sda_s2_ff};
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
			end
			if (scl_rise && sb_state_ff == xcvr_mgmt_pkg::SB_RACK)
				nack_ff <= sda_s2_ff;
			case (sb_state_ff)
				xcvr_mgmt_pkg::SB_IDLE: sda_oe_n_ff <= 1'b1;
				xcvr_mgmt_pkg::SB_ADDR:
					if (byte_end)
					begin
						if (shift_ff[7:1] == DEV_ADDR)
						begin
							sb_state_ff  <= xcvr_mgmt_pkg::SB_AACK;
							sda_oe_n_ff  <= 1'b0;
							rw_ff        <= shift_ff[0];
							ofs_valid_ff <= 1'b0;
						end
						else
							sb_state_ff <= xcvr_mgmt_pkg::SB_IDLE;
					end
				xcvr_mgmt_pkg::SB_AACK, xcvr_mgmt_pkg::SB_RACK:
					if (scl_fall)
					begin
						bit_cnt_ff <= 4'h0;
						if (sb_state_ff == xcvr_mgmt_pkg::SB_RACK && nack_ff)
						begin
							sb_state_ff <= xcvr_mgmt_pkg::SB_IDLE;
							sda_oe_n_ff <= 1'b1;
						end
						else if (rw_ff)
						begin
							sb_state_ff <= xcvr_mgmt_pkg::SB_RTX;
							if (sb_state_ff == xcvr_mgmt_pkg::SB_RACK)
							begin
								ofs_ff      <= ofs_nx;
								shift_ff    <= rd_next;
								sda_oe_n_ff <= rd_next[7];
								if (ofs_nx == `LO_FLAGS)
								begin
									clr_pend_ff <= 1'b1;
									clr_bits_ff <= flags_ff;
								end
							end
							else
							begin
								shift_ff    <= rd_now;
								sda_oe_n_ff <= rd_now[7];
								if (ofs_ff == `LO_FLAGS)
								begin
									clr_pend_ff <= 1'b1;
									clr_bits_ff <= flags_ff;
								end
							end
						end
						else
						begin
							sb_state_ff <= xcvr_mgmt_pkg::SB_WRX;
							sda_oe_n_ff <= 1'b1;
						end
					end
				xcvr_mgmt_pkg::SB_WRX:
					if (byte_end)
					begin
						sb_state_ff  <= xcvr_mgmt_pkg::SB_WACK;
						sda_oe_n_ff  <= 1'b0;
						ofs_valid_ff <= 1'b1;
						ofs_ff       <= ofs_valid_ff ? ofs_nx : shift_ff;
					end
				xcvr_mgmt_pkg::SB_WACK:
					if (scl_fall)
					begin
						sb_state_ff <= xcvr_mgmt_pkg::SB_WRX;
						sda_oe_n_ff <= 1'b1;
						bit_cnt_ff  <= 4'h0;
					end
				xcvr_mgmt_pkg::SB_RTX:
					if (byte_end)
					begin
						sb_state_ff <= xcvr_mgmt_pkg::SB_RACK;
						sda_oe_n_ff <= 1'b1;
						nack_ff     <= 1'b1;
					end
					else if (scl_fall)
					begin
						sda_oe_n_ff <= shift_ff[6];
						shift_ff    <= {shift_ff[6:0], 1'b0};
					end
				default: sb_state_ff <= xcvr_mgmt_pkg::SB_IDLE;
			endcase
		end
	end

	// host writes: mask and page select; a module reset returns them to defaults
	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			mask_ff <= `MASK_RESET;
			page_ff <= `PAGE_RESET;
		end
		else if (hold_ff)
		begin
			mask_ff <= `MASK_RESET;
			page_ff <= `PAGE_RESET;
		end
		else if (wr_stb && ofs_ff == `LO_MASK)
			mask_ff <= shift_ff;
		else if (wr_stb && ofs_ff == `LO_PAGE_SEL)
			page_ff <= shift_ff;
	end

	// user page storage; contents survive resets like the nonvolatile array they model
	always_ff @(posedge mclk_in)
	begin
		if (wr_stb && ofs_ff[7] && page_ff == `PAGE_USER)
			user_mem_ff[ofs_ff[6:0]] <= shift_ff;
	end

	// flags: set wins over a read clear in the same cycle
	xcvr_mgmt_pkg::flags_t flag_set;
	logic                  flags_ready_seen_ff;
	assign flag_set = '{init_done: ready_ff & (init_state_ff == xcvr_mgmt_pkg::INIT_RUN)
		& ~flags_ready_seen_ff, tx_fault: flt_s2_ff & ready_ff, rx_los: los_s2_ff & ready_ff};

	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			flags_ff            <= '0;
			flags_ready_seen_ff <= 1'b0;
		end
		else if (hold_ff)
		begin
			flags_ff            <= '0;
			flags_ready_seen_ff <= 1'b0;
		end
		else
		begin
			flags_ready_seen_ff <= flags_ready_seen_ff | flag_set.init_done;
			flags_ff <= (flags_ff & ~(clr_stb ? clr_bits_ff : '0)) | flag_set;
		end
	end

	// pin outputs
	logic irq_n_ff, lp_active_ff;

	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			irq_n_ff     <= 1'b1;
			lp_active_ff <= 1'b1;
		end
		else
		begin
			irq_n_ff     <= ~|(flags_ff & ~mask_ff[2:0]);
			lp_active_ff <= lp_s2_ff;
		end
	end

	assign sda_out                 = 1'b0;
	assign sda_oe_n_out            = sda_oe_n_ff;
	assign interrupt_request_n_out = irq_n_ff;
	assign low_power_active_out    = lp_active_ff;
	assign ready_out               = ready_ff;

	// checks
	int unsigned since_rel_cnt;
	always_ff @(posedge mclk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			since_rel_cnt <= 0;
		else if (hold_ff || ready_ff)
			since_rel_cnt <= 0;
		else
			since_rel_cnt <= since_rel_cnt + 1;
	end

	chk_init_bound: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		since_rel_cnt <= INIT_CYCLES) else $error("init took too long");
	chk_short_reset: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		mrst_s2_ff ##1 (!mrst_s2_ff)[*5] ##1 mrst_s2_ff |-> !hold_ff)
		else $error("short reset pulse acted");
	chk_quiet_unready: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		!ready_ff |=> sda_oe_n_out) else $error("bus driven before ready");
	chk_ready_irq: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		$rose(ready_ff) && !mask_ff[2] |-> ##2 !interrupt_request_n_out)
		else $error("no interrupt at ready");
	chk_lp_entry: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		$rose(lp_s2_ff) |=> low_power_active_out) else $error("low power late");
	chk_irq_assert: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		|(flags_ff & ~mask_ff[2:0]) |=> !interrupt_request_n_out)
		else $error("interrupt not asserted");
	chk_irq_release: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		(flags_ff & ~mask_ff[2:0]) == 3'h0 |=> interrupt_request_n_out)
		else $error("interrupt not released");
	chk_los_flag: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		los_s2_ff && ready_ff && !hold_ff |=> flags_ff.rx_los) else $error("los flag late");
	chk_read_clear: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		clr_stb && clr_bits_ff.rx_los && !los_s2_ff && !hold_ff |=> !flags_ff.rx_los)
		else $error("los flag not cleared");
	chk_user_write: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		wr_stb && ofs_ff[7] && page_ff == `PAGE_USER
		|=> user_mem_ff[$past(ofs_ff[6:0])] == $past(shift_ff))
		else $error("user page not written");
	chk_page_write: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
		wr_stb && ofs_ff == `LO_PAGE_SEL && !hold_ff |=> page_ff == $past(shift_ff))
		else $error("page select not written");

	cov_ready: cover property (@(posedge mclk_in) disable iff (!reset_n_in) $rose(ready_ff));
	cov_read_ack: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
		sb_state_ff == xcvr_mgmt_pkg::SB_RACK && scl_fall && !nack_ff);
	cov_user_wr: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
		wr_stb && page_ff == `PAGE_USER);
	cov_clear: cover property (@(posedge mclk_in) disable iff (!reset_n_in) clr_stb);

endmodule : xcvr_mgmt

// File: verif/host_i2c.sv
// host side of the two-wire bus, bit-level tasks
module host_i2c (
	input  wire logic mclk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge mclk_in);
	endtask : tick

	// sda moves one cycle after the scl fall so no false start is seen
	task automatic bit_io(input logic b, output logic r);
		tick(1);
		sda_out = b;
		tick(3);
		scl_out = 1'b1;
		tick(2);
		r = sda_in;
		tick(2);
		scl_out = 1'b0;
	endtask : bit_io

	task automatic start();
		tick(1);
		sda_out = 1'b1;
		tick(3);
		scl_out = 1'b1;
		tick(4);
		sda_out = 1'b0;
		tick(4);
		scl_out = 1'b0;
	endtask : start

	task automatic stop();
		tick(1);
		sda_out = 1'b0;
		tick(3);
		scl_out = 1'b1;
		tick(4);
		sda_out = 1'b1;
		tick(4);
	endtask : stop

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask : wbyte

	task automatic rbyte(output logic [7:0] d, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask : rbyte
endmodule : host_i2c

// File: verif/xcvr_mgmt_tb.sv
// self-checking bench of the transceiver management block
`include "xcvr_mgmt_consts.svh"
module xcvr_mgmt_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0]   BR  = 8'hfa;
	localparam logic [15:0]  WL  = 16'h6590;
	localparam logic [15:0]  TOL = 16'h0514;
	localparam logic [127:0] SN  = "SN0123456789ABCD";
	logic       mclk_in    = 1'b0;
	logic       reset_n_in = 1'b0;
	logic       mrst_n     = 1'b1;
	logic       lpreq      = 1'b0;
	logic       los        = 1'b0;
	logic       txf        = 1'b0;
	logic       scl;
	logic       hsda;
	logic       sda_o;
	logic       sda_oe_n;
	logic       irq_n;
	logic       lp_act;
	logic       rdy;
	logic [7:0] rb [0:95];
	int         failures   = 0;
	int         checks     = 0;
	wire        sda        = hsda & (sda_oe_n | sda_o);

	always #20 mclk_in = ~mclk_in;

	xcvr_mgmt #(.INIT_CYCLES(1000), .SETTLE_CYCLES(20), .BIT_RATE(BR), .SMF_KM(8'h0a),
		.EMM50_2M(8'h05), .WAVELEN(WL), .WAVE_TOL(TOL), .SERIAL_NUM(SN)) u_xcvr_mgmt (
		.mclk_in(mclk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .module_reset_n_in(mrst_n),
		.low_power_request_in(lpreq), .rx_los_in(los), .tx_fault_in(txf),
		.interrupt_request_n_out(irq_n), .low_power_active_out(lp_act), .ready_out(rdy));

	host_i2c u_host_i2c (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl), .sda_out(hsda));

	task automatic stop_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task automatic cmp(input logic [7:0] e, input logic [7:0] g, input string m);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %0t %s exp %h got %h", $time, m, e, g);
		end
	endtask : cmp

	task automatic cmp_b(input logic e, input logic g, input string m);
		cmp({7'h00, e}, {7'h00, g}, m);
	endtask : cmp_b

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_in);
	endtask : cyc

	task automatic wait_rdy();
		for (int i = 0; i < 400 && rdy !== 1'b1; i++)
			cyc(1);
	endtask : wait_rdy

	task automatic hdr(input logic [7:0] off);
		logic a;
		u_host_i2c.start();
		u_host_i2c.wbyte(8'ha0, a);
		cmp_b(1'b1, a, "addr ack");
		u_host_i2c.wbyte(off, a);
		cmp_b(1'b1, a, "offset ack");
	endtask : hdr

	task automatic wr(input logic [7:0] off, input logic [7:0] d);
		logic a;
		hdr(off);
		u_host_i2c.wbyte(d, a);
		cmp_b(1'b1, a, "data ack");
		u_host_i2c.stop();
	endtask : wr

	task automatic rd(input logic [7:0] off, input int n);
		logic a;
		hdr(off);
		u_host_i2c.start();
		u_host_i2c.wbyte(8'ha1, a);
		cmp_b(1'b1, a, "read addr ack");
		for (int i = 0; i < n; i++)
			u_host_i2c.rbyte(rb[i], i == n - 1);
		u_host_i2c.stop();
	endtask : rd

	initial
	begin
		repeat (60000) @(posedge mclk_in);
		failures++;
		stop_test();
	end

	initial
	begin
		logic [7:0] bs;
		logic [7:0] es;
		logic       ak;
		cyc(12);
		reset_n_in = 1'b1;
		wait_rdy();
		cmp_b(1'b1, rdy, "ready");
		cyc(4);
		cmp_b(1'b0, irq_n, "init irq");
		rd(`LO_STATUS, 2);
		cmp_b(1'b0, rb[0][`STATUS_NOT_READY], "not ready");
		cmp(8'h04, rb[1], "init flag");
		cyc(8);
		cmp_b(1'b1, irq_n, "irq off");
		rd(`LO_MASK, 1);
		cmp(`MASK_RESET, rb[0], "mask rst");
		$display("test init end");
		rd(`ID_TYPE_CODE, 96);
		bs = 8'h00;
		es = 8'h00;
		for (int i = 0; i < 63; i++)
			bs += rb[i];
		for (int i = 64; i < 95; i++)
			es += rb[i];
		cmp(bs, rb[63], "base sum");
		cmp(es, rb[95], "ext sum");
		cmp(BR, rb[12], "bit rate");
		cmp(8'h0a, rb[14], "smf");
		cmp(8'h05, rb[15], "emm50");
		cmp(WL[15:8], rb[58], "wl hi");
		cmp(WL[7:0], rb[59], "wl lo");
		cmp(TOL[15:8], rb[60], "tol hi");
		cmp(TOL[7:0], rb[61], "tol lo");
		cmp(8'h53, rb[68], "sn first");
		cmp(8'h44, rb[83], "sn last");
		wr(`ID_BIT_RATE, 8'h00);
		rd(`ID_BIT_RATE, 1);
		cmp(BR, rb[0], "ro byte");
		$display("test id end");
		los = 1'b1;
		cyc(8);
		cmp_b(1'b0, irq_n, "los irq");
		los = 1'b0;
		cyc(8);
		cmp_b(1'b0, irq_n, "los held");
		rd(`LO_FLAGS, 1);
		cmp(8'h01, rb[0], "los flag");
		cyc(8);
		cmp_b(1'b1, irq_n, "irq release");
		txf = 1'b1;
		cyc(8);
		cmp_b(1'b0, irq_n, "fault irq");
		txf = 1'b0;
		rd(`LO_FLAGS, 2);
		cmp(8'h02, rb[0], "fault flag");
		rd(`LO_FLAGS, 1);
		cmp(8'h00, rb[0], "flags clr");
		$display("test flags end");
		wr(`LO_MASK, 8'h01);
		los = 1'b1;
		cyc(8);
		cmp_b(1'b1, irq_n, "masked");
		wr(`LO_MASK, 8'h00);
		cyc(8);
		cmp_b(1'b0, irq_n, "unmasked");
		los = 1'b0;
		cyc(8);
		rd(`LO_FLAGS, 1);
		cmp(8'h01, rb[0], "masked flag");
		$display("test mask end");
		wr(`LO_PAGE_SEL, `PAGE_USER);
		wr(8'h80, 8'h5a);
		rd(8'h80, 1);
		cmp(8'h5a, rb[0], "user page");
		wr(`LO_PAGE_SEL, `PAGE_ID);
		rd(`ID_BIT_RATE, 1);
		cmp(BR, rb[0], "id page");
		$display("test page end");
		lpreq = 1'b1;
		cyc(5);
		cmp_b(1'b1, lp_act, "lp on");
		lpreq = 1'b0;
		cyc(5);
		cmp_b(1'b0, lp_act, "lp off");
		$display("test lp end");
		wr(`LO_PAGE_SEL, `PAGE_USER);
		mrst_n = 1'b0;
		cyc(5);
		mrst_n = 1'b1;
		cyc(5);
		mrst_n = 1'b0;
		cyc(45);
		mrst_n = 1'b1;
		cyc(5);
		cmp_b(1'b1, rdy, "short rst");
		mrst_n = 1'b0;
		cyc(60);
		cmp_b(1'b0, rdy, "long rst");
		u_host_i2c.start();
		u_host_i2c.wbyte(8'ha0, ak);
		cmp_b(1'b0, ak, "unready ack");
		u_host_i2c.stop();
		mrst_n = 1'b1;
		wait_rdy();
		cmp_b(1'b1, rdy, "re-init");
		rd(`LO_PAGE_SEL, 1);
		cmp(`PAGE_RESET, rb[0], "page rst");
		$display("test reset end");
		stop_test();
	end
endmodule : xcvr_mgmt_tb
